// ==== design/apf_regs.sv ====
// Purpose: Arbitration control and pin function select registers on APB.
// Assumes: Straps and the interrupt pending level are synchronous inputs.
// Notes: Straps are sampled while srst is high to seed port C, D and F.
//
// Contract
// - Mask bit clear keeps bridge default grant
// - Boost active follows unmasked core interrupt
// - Boost active only under fixed priority
// - Boost enable raises core to second
// - Boost enable needs both buses fixed
// - Master bus mode: fixed or rotating
// - Core bus mode: fixed or rotating
// - Port I selects GPIO or watchdog
// - Port H selects GPIO or interrupts
// - Port G fields choose GPIO, I2C, serial
// - Port E bits choose PCI or UARTs
// - Port D fields choose GPIO or PCI
// - Port C field chooses GPIO or PCI
//
// Added by the designer: the APB slave port.

`timescale 1ns/1ps

module apf_regs (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic strap_pci,
	input wire logic strap_rmii,
	input wire logic cpu_irq_pending,
	output logic default_grant_mask,
	output logic master_bus_priority_mode,
	output logic cpu_bus_priority_mode,
	output logic cpu_priority_second,
	output logic priority_boost_active,
	output logic port_i_watchdog,
	output logic port_h_irq,
	output logic [1:0] port_g_i2c,
	output logic [1:0] port_g_serial,
	output logic [1:0] port_e_pci,
	output logic [2:0] port_e_uart,
	output logic [1:0] port_d_pci,
	output logic port_c_pci,
	output logic port_f_rmii
);

	// ****************************************************************
	// Bus front end
	// ****************************************************************
	logic hit_arb;
	logic hit_pin;
	logic wr_arb;
	logic wr_pin;
	logic rd_setup;

	apf_apb_slave u_apb (
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.hit_arb(hit_arb),
		.hit_pin(hit_pin),
		.wr_arb(wr_arb),
		.wr_pin(wr_pin),
		.rd_setup(rd_setup),
		.pready(pready),
		.pslverr(pslverr)
	);

	// ****************************************************************
	// Write data merge
	// ****************************************************************
	logic [31:0] arb_word;
	logic [31:0] pin_word;
	logic [31:0] arb_next;
	logic [31:0] pin_next;

	assign arb_next = apf_pkg::apf_merge(arb_word, pwdata, pstrb,
		apf_pkg::ARB_WRITE_MASK);
	assign pin_next = apf_pkg::apf_merge(pin_word, pwdata, pstrb,
		apf_pkg::PIN_WRITE_MASK);

	// ****************************************************************
	// Arbitration control
	// ****************************************************************
	logic default_grant_mask_reg;
	logic boost_en_reg;
	logic master_mode_reg;
	logic cpu_mode_reg;
	logic boost_act_reg;
	logic boost_ok_reg;
	logic both_fixed;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			default_grant_mask_reg <= apf_pkg::ARB_RESET[apf_pkg::ARB_DEFAULT_GRANT_MASK_BIT];
		end else if (ce && wr_arb) begin
			default_grant_mask_reg <= arb_next[apf_pkg::ARB_DEFAULT_GRANT_MASK_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boost_en_reg <= apf_pkg::ARB_RESET[apf_pkg::ARB_BOOST_EN_BIT];
		end else if (ce && wr_arb) begin
			boost_en_reg <= arb_next[apf_pkg::ARB_BOOST_EN_BIT];
		end
	end

	// ****************************************************************
	// Priority modes
	// ****************************************************************
	// master bus mode
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			master_mode_reg <=
				apf_pkg::ARB_RESET[apf_pkg::ARB_MASTER_MODE_BIT];
		end else if (ce && wr_arb) begin
			master_mode_reg <= arb_next[apf_pkg::ARB_MASTER_MODE_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cpu_mode_reg <= apf_pkg::ARB_RESET[apf_pkg::ARB_CPU_MODE_BIT];
		end else if (ce && wr_arb) begin
			cpu_mode_reg <= arb_next[apf_pkg::ARB_CPU_MODE_BIT];
		end
	end

	assign both_fixed = ~master_mode_reg & ~cpu_mode_reg;

	// ****************************************************************
	// Priority boost
	// ****************************************************************
	// boost gated by fixed modes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boost_ok_reg <= 1'b0;
		end else if (ce) begin
			boost_ok_reg <= boost_en_reg & both_fixed;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boost_act_reg <= 1'b0;
		end else if (ce) begin
			boost_act_reg <= boost_en_reg & both_fixed & cpu_irq_pending;
		end
	end

	// ****************************************************************
	// Arbitration word
	// ****************************************************************
	assign arb_word = {27'h0, default_grant_mask_reg, boost_act_reg, boost_en_reg,
		master_mode_reg, cpu_mode_reg};

	// ****************************************************************
	// Pin function select
	// ****************************************************************
	logic port_i_reg;
	logic port_h_reg;
	logic [1:0] port_g_hi_reg;
	logic [1:0] port_g_lo_reg;
	logic [1:0] port_e_pci_reg;
	logic [2:0] port_e_uart_reg;
	logic [1:0] port_d_hi_reg;
	logic [1:0] port_d_lo_reg;
	logic [1:0] port_c_reg;
	logic port_f_reg;

	// ****************************************************************
	// Ports I and H
	// ****************************************************************
	// port I select
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_i_reg <= apf_pkg::PIN_RESET[apf_pkg::PIN_I_BIT];
		end else if (ce && wr_pin) begin
			port_i_reg <= pin_next[apf_pkg::PIN_I_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_h_reg <= apf_pkg::PIN_RESET[apf_pkg::PIN_H_BIT];
		end else if (ce && wr_pin) begin
			port_h_reg <= pin_next[apf_pkg::PIN_H_BIT];
		end
	end

	// ****************************************************************
	// Port G fields
	// ****************************************************************
	// port G high field
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_g_hi_reg <= apf_pkg::PIN_RESET[apf_pkg::PIN_G_HI_LSB+:2];
		end else if (ce && wr_pin) begin
			port_g_hi_reg <= pin_next[apf_pkg::PIN_G_HI_LSB+:2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_g_lo_reg <= apf_pkg::PIN_RESET[apf_pkg::PIN_G_LO_LSB+:2];
		end else if (ce && wr_pin) begin
			port_g_lo_reg <= pin_next[apf_pkg::PIN_G_LO_LSB+:2];
		end
	end

	// ****************************************************************
	// Port E routes
	// ****************************************************************
	// port E PCI bits
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_e_pci_reg <=
				apf_pkg::PIN_RESET[apf_pkg::PIN_E_PCI_MID_BIT+:2];
		end else if (ce && wr_pin) begin
			port_e_pci_reg <= pin_next[apf_pkg::PIN_E_PCI_MID_BIT+:2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_e_uart_reg <=
				apf_pkg::PIN_RESET[apf_pkg::PIN_E_UART0_BIT+:3];
		end else if (ce && wr_pin) begin
			port_e_uart_reg <= pin_next[apf_pkg::PIN_E_UART0_BIT+:3];
		end
	end

	// ****************************************************************
	// Strap seeded fields
	// ****************************************************************
	// port D high strap default
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_d_hi_reg <= strap_pci ? apf_pkg::SEL_ALT1 :
				apf_pkg::SEL_GPIO;
		end else if (ce && wr_pin) begin
			port_d_hi_reg <= pin_next[apf_pkg::PIN_D_HI_LSB+:2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_d_lo_reg <= strap_pci ? apf_pkg::SEL_ALT1 :
				apf_pkg::SEL_GPIO;
		end else if (ce && wr_pin) begin
			port_d_lo_reg <= pin_next[apf_pkg::PIN_D_LO_LSB+:2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_c_reg <= strap_pci ? apf_pkg::SEL_ALT1 : apf_pkg::SEL_GPIO;
		end else if (ce && wr_pin) begin
			port_c_reg <= pin_next[apf_pkg::PIN_C_LSB+:2];
		end
	end

	// Port F follows the interface strap after reset.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_f_reg <= strap_rmii;
		end else if (ce && wr_pin) begin
			port_f_reg <= pin_next[apf_pkg::PIN_F_BIT];
		end
	end

	// ****************************************************************
	// Pin function word
	// ****************************************************************
	// reserved bits zero
	assign pin_word = {4'h0, port_i_reg, 2'h0, port_h_reg, 6'h0,
		port_g_hi_reg, port_g_lo_reg, 1'b0, port_e_pci_reg,
		port_e_uart_reg, port_d_hi_reg, port_d_lo_reg, port_c_reg,
		port_f_reg, 1'b0};

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			if (hit_arb) begin
				prdata <= arb_word & apf_pkg::ARB_READ_MASK;
			end else if (hit_pin) begin
				prdata <= pin_word;
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// Arbiter outputs
	// ****************************************************************
	assign default_grant_mask = default_grant_mask_reg;
	assign master_bus_priority_mode = master_mode_reg;
	assign cpu_bus_priority_mode = cpu_mode_reg;
	assign cpu_priority_second = boost_ok_reg;
	assign priority_boost_active = boost_act_reg;

	// ****************************************************************
	// Pin function decode
	// ****************************************************************
	apf_pin_decode u_decode (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.sel_word(pin_word),
		.port_i_watchdog(port_i_watchdog),
		.port_h_irq(port_h_irq),
		.port_g_i2c(port_g_i2c),
		.port_g_serial(port_g_serial),
		.port_e_pci(port_e_pci),
		.port_e_uart(port_e_uart),
		.port_d_pci(port_d_pci),
		.port_c_pci(port_c_pci),
		.port_f_rmii(port_f_rmii)
	);

endmodule

// ==== design/apf_pkg.sv ====
// Purpose: Shared constants for the arbitration and pin function registers.
// Assumes: 32-bit APB data, registers at full byte addresses.
// Notes: Field positions, reset values and write masks live here; ports C, D and F reset from straps.

package apf_pkg;

	// ****************************************************************
	// Register addresses and reset values
	// ****************************************************************
	localparam logic [31:0] ARB_ADDR = 32'hB000_0008;
	localparam logic [31:0] PIN_ADDR = 32'hB000_000C;
	localparam logic [31:0] ARB_RESET = 32'h0000_0000;
	localparam logic [31:0] PIN_RESET = 32'h0800_0000;
	localparam logic [31:0] ARB_WRITE_MASK = 32'h0000_0017;
	localparam logic [31:0] ARB_READ_MASK = 32'h0000_001F;
	localparam logic [31:0] PIN_WRITE_MASK = 32'h0903_DFFE;

	// ****************************************************************
	// Arbitration control fields
	// ****************************************************************
	localparam int ARB_CPU_MODE_BIT = 0;
	localparam int ARB_MASTER_MODE_BIT = 1;
	localparam int ARB_BOOST_EN_BIT = 2;
	localparam int ARB_BOOST_ACT_BIT = 3;
	localparam int ARB_DEFAULT_GRANT_MASK_BIT = 4;

	// ****************************************************************
	// Pin function select fields
	// ****************************************************************
	localparam int PIN_F_BIT = 1;
	localparam int PIN_C_LSB = 2;
	localparam int PIN_D_LO_LSB = 4;
	localparam int PIN_D_HI_LSB = 6;
	localparam int PIN_E_UART0_BIT = 8;
	localparam int PIN_E_UART1_BIT = 9;
	localparam int PIN_E_UART2_BIT = 10;
	localparam int PIN_E_PCI_MID_BIT = 11;
	localparam int PIN_E_PCI_HI_BIT = 12;
	localparam int PIN_G_LO_LSB = 14;
	localparam int PIN_G_HI_LSB = 16;
	localparam int PIN_H_BIT = 24;
	localparam int PIN_I_BIT = 27;

	// ****************************************************************
	// Two-bit select codes
	// ****************************************************************
	localparam logic [1:0] SEL_GPIO = 2'h0;
	localparam logic [1:0] SEL_ALT1 = 2'h1;
	localparam logic [1:0] SEL_ALT2 = 2'h2;

	// Merges write data into a word under byte strobes and a field mask.
	function automatic logic [31:0] apf_merge(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		lanes = lanes & mask;
		return (old_val & ~lanes) | (new_val & lanes);
	endfunction

	// Tells whether a two-bit field holds the given code.
	function automatic logic apf_is_code(input logic [31:0] word,
		input int lsb, input logic [1:0] code);
		return word[lsb+:2] == code;
	endfunction

endpackage

// ==== design/apf_apb_slave.sv ====
// Purpose: APB address decode and handshake for the register bank.
// Assumes: Zero wait states; ce low stretches the access phase.
// Notes: Unmapped addresses answer with pslverr in the access phase.

`timescale 1ns/1ps

module apf_apb_slave (
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	output logic hit_arb,
	output logic hit_pin,
	output logic wr_arb,
	output logic wr_pin,
	output logic rd_setup,
	output logic pready,
	output logic pslverr
);

	// ****************************************************************
	// Decode and strobes
	// ****************************************************************
	logic access;

	assign hit_arb = paddr == apf_pkg::ARB_ADDR;
	assign hit_pin = paddr == apf_pkg::PIN_ADDR;
	assign access = psel & penable & ce;
	assign wr_arb = access & pwrite & hit_arb;
	assign wr_pin = access & pwrite & hit_pin;
	assign rd_setup = psel & ~penable & ce;
	assign pready = ce;
	assign pslverr = access & ~(hit_arb | hit_pin);

endmodule

// ==== design/apf_pin_decode.sv ====
// Purpose: Registered decode of the pin function select word.
// Assumes: Reserved codes leave the pins as GPIO.
// Notes: Outputs follow the register one cycle later.

`timescale 1ns/1ps

module apf_pin_decode (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [31:0] sel_word,
	output logic port_i_watchdog,
	output logic port_h_irq,
	output logic [1:0] port_g_i2c,
	output logic [1:0] port_g_serial,
	output logic [1:0] port_e_pci,
	output logic [2:0] port_e_uart,
	output logic [1:0] port_d_pci,
	output logic port_c_pci,
	output logic port_f_rmii
);

	// ****************************************************************
	// Function outputs
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port_i_watchdog <= apf_pkg::PIN_RESET[apf_pkg::PIN_I_BIT];
			port_h_irq <= 1'b0;
			port_g_i2c <= 2'h0;
			port_g_serial <= 2'h0;
			port_e_pci <= 2'h0;
			port_e_uart <= 3'h0;
			port_d_pci <= 2'h0;
			port_c_pci <= 1'b0;
			port_f_rmii <= 1'b0;
		end else if (ce) begin
			port_i_watchdog <= sel_word[apf_pkg::PIN_I_BIT];
			port_h_irq <= sel_word[apf_pkg::PIN_H_BIT];
			port_g_i2c <= {
				apf_pkg::apf_is_code(sel_word, apf_pkg::PIN_G_HI_LSB,
					apf_pkg::SEL_ALT1),
				apf_pkg::apf_is_code(sel_word, apf_pkg::PIN_G_LO_LSB,
					apf_pkg::SEL_ALT1)};
			port_g_serial <= {
				apf_pkg::apf_is_code(sel_word, apf_pkg::PIN_G_HI_LSB,
					apf_pkg::SEL_ALT2),
				apf_pkg::apf_is_code(sel_word, apf_pkg::PIN_G_LO_LSB,
					apf_pkg::SEL_ALT2)};
			port_e_pci <= {sel_word[apf_pkg::PIN_E_PCI_HI_BIT],
				sel_word[apf_pkg::PIN_E_PCI_MID_BIT]};
			port_e_uart <= {sel_word[apf_pkg::PIN_E_UART2_BIT],
				sel_word[apf_pkg::PIN_E_UART1_BIT],
				sel_word[apf_pkg::PIN_E_UART0_BIT]};
			port_d_pci <= {
				apf_pkg::apf_is_code(sel_word, apf_pkg::PIN_D_HI_LSB,
					apf_pkg::SEL_ALT1),
				apf_pkg::apf_is_code(sel_word, apf_pkg::PIN_D_LO_LSB,
					apf_pkg::SEL_ALT1)};
			port_c_pci <= apf_pkg::apf_is_code(sel_word,
				apf_pkg::PIN_C_LSB, apf_pkg::SEL_ALT1);
			port_f_rmii <= sel_word[apf_pkg::PIN_F_BIT];
		end
	end

endmodule

// ==== bench/apf_regs_properties.sv ====
// Purpose: Port checker for the arbitration and pin function registers.
// Assumes: One clock, synchronous active high reset.
// Notes: Bound to apf_regs after the module.

`timescale 1ns/1ps

module apf_regs_chk (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pslverr,
	input wire logic cpu_irq_pending,
	input wire logic default_grant_mask,
	input wire logic master_bus_priority_mode,
	input wire logic cpu_bus_priority_mode,
	input wire logic cpu_priority_second,
	input wire logic priority_boost_active,
	input wire logic port_i_watchdog,
	input wire logic port_h_irq
);
	// ********
	// Assertions
	// ********
	logic acc, wa, wp;
	assign acc = psel && penable && pwrite && ce;
	assign wa = acc && paddr == apf_pkg::ARB_ADDR;
	assign wp = acc && paddr == apf_pkg::PIN_ADDR;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	AST_UNMAPPED: assert property (
		psel && penable && ce |-> pslverr ==
		(paddr != apf_pkg::ARB_ADDR && paddr != apf_pkg::PIN_ADDR))
		else $error("bad slave error");
	AST_MASK: assert property (wa && pstrb[0] |=>
		default_grant_mask == $past(pwdata[4])) else $error("mask lost");
	AST_MASTER_MODE: assert property (wa && pstrb[0] |=>
		master_bus_priority_mode == $past(pwdata[1]))
		else $error("mode lost");
	AST_CPU_MODE: assert property (wa && pstrb[0] |=>
		cpu_bus_priority_mode == $past(pwdata[0])) else $error("mode lost");
	AST_BOOST_ON: assert property (
		wa && pstrb[0] && pwdata[2:0] == 3'h4 |=> ##1 cpu_priority_second)
		else $error("core not raised");
	AST_FIXED_ONLY: assert property (ce &&
		(master_bus_priority_mode || cpu_bus_priority_mode) |=>
		!cpu_priority_second) else $error("boost under rotation");
	AST_ACTIVE: assert property (ce |=> priority_boost_active ==
		(cpu_priority_second && $past(cpu_irq_pending)))
		else $error("active flag wrong");
	AST_WATCHDOG: assert property (wp && pstrb[3] |=>
		##1 port_i_watchdog == $past(pwdata[27], 2))
		else $error("watchdog pin");
	AST_IRQ_PINS: assert property (wp && pstrb[3] |=>
		##1 port_h_irq == $past(pwdata[24], 2)) else $error("irq pins");

	COV_ARB_WRITE: cover property (wa);
	COV_BOOST: cover property (priority_boost_active);
	COV_UNMAPPED: cover property (psel && penable && pslverr);
endmodule

bind apf_regs apf_regs_chk u_apf_regs_chk (.*);

// ==== bench/test_arbitration_and_pin_function_regs.sv ====
// Purpose: Self-checking bench for the arbitration and pin function registers.
// Assumes: APB master at 40 MHz, straps low until the strap test.
// Notes: Decode outputs are checked one edge after the register.

`timescale 1ns/1ps

module test_arbitration_and_pin_function_regs;
	logic sys_clk, srst, ce, psel, penable, pwrite;
	logic strap_pci, strap_rmii, cpu_irq_pending, err;
	logic pready, pslverr, default_grant_mask, master_bus_priority_mode;
	logic cpu_bus_priority_mode, cpu_priority_second, priority_boost_active;
	logic port_i_watchdog, port_h_irq, port_c_pci, port_f_rmii;
	logic [1:0] port_g_i2c, port_g_serial, port_e_pci, port_d_pci;
	logic [2:0] port_e_uart;
	logic [3:0] pstrb;
	logic [14:0] pin_dec;
	logic [31:0] paddr, pwdata, prdata, rd_val;
	int error_cnt, checks, cyc;

	apf_regs u_apf_regs (.*);

	assign pin_dec = {port_i_watchdog, port_h_irq, port_g_i2c, port_g_serial,
		port_e_pci, port_e_uart, port_d_pci, port_c_pci, port_f_rmii};

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ********
	// Shared tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("errors=%0d checks=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd_val = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [31:0] a);
		apb(1'b0, a, 32'h0, 4'h0);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		rd(apf_pkg::ARB_ADDR);
		chk(rd_val, 32'h0);
		rd(apf_pkg::PIN_ADDR);
		chk(rd_val, 32'h0800_0000);
		chk({31'h0, port_i_watchdog}, 32'h1);
	endtask

	task automatic t_arb();
		wr(apf_pkg::ARB_ADDR, 32'hFFFF_FFFF);
		rd(apf_pkg::ARB_ADDR);
		chk(rd_val, 32'h17);
		chk({29'h0, default_grant_mask, master_bus_priority_mode,
			cpu_bus_priority_mode}, 32'h7);
		chk({31'h0, cpu_priority_second}, 32'h0);
		cpu_irq_pending <= 1'b1;
		wr(apf_pkg::ARB_ADDR, 32'h4);
		rd(apf_pkg::ARB_ADDR);
		chk(rd_val, 32'hC);
		chk({29'h0, default_grant_mask, cpu_priority_second,
			priority_boost_active}, 32'h3);
		wr(apf_pkg::ARB_ADDR, 32'h5);
		rd(apf_pkg::ARB_ADDR);
		chk(rd_val, 32'h5);
		wr(apf_pkg::ARB_ADDR, 32'h2);
		rd(apf_pkg::ARB_ADDR);
		chk({29'h0, default_grant_mask, master_bus_priority_mode,
			cpu_bus_priority_mode}, 32'h2);
		chk({31'h0, cpu_priority_second}, 32'h0);
		cpu_irq_pending <= 1'b0;
	endtask

	task automatic t_pin();
		logic [31:0] val [6] = '{32'h0, 32'hFFFF_FFFF, 32'h0001_4054,
			32'h0002_80A8, 32'h0102_4040, 32'h0800_1502};
		logic [31:0] dec [6] = '{32'h0, 32'h61F1, 32'h180E, 32'h600,
			32'h2C08, 32'h4151};
		for (int i = 0; i < 6; i++) begin
			wr(apf_pkg::PIN_ADDR, val[i]);
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk({17'h0, pin_dec}, dec[i]);
			rd(apf_pkg::PIN_ADDR);
			chk(rd_val, val[i] & 32'h0903_DFFE);
		end
	endtask

	task automatic t_strobe();
		apb(1'b1, apf_pkg::PIN_ADDR, 32'h0, 4'h7);
		rd(apf_pkg::PIN_ADDR);
		chk(rd_val, 32'h0800_0000);
		apb(1'b1, apf_pkg::ARB_ADDR, 32'hFFFF_FFFF, 4'h0);
		rd(apf_pkg::ARB_ADDR);
		chk(rd_val, 32'h2);
	endtask

	task automatic t_unmapped();
		wr(32'hB000_0010, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h1);
		rd(32'hB000_0004);
		chk({31'h0, err}, 32'h1);
		chk(rd_val, 32'h0);
		rd(apf_pkg::ARB_ADDR);
		chk({31'h0, err}, 32'h0);
		chk(rd_val, 32'h2);
	endtask

	task automatic t_stall();
		ce <= 1'b0;
		fork
			wr(apf_pkg::ARB_ADDR, 32'h10);
			begin
				repeat (3) @(posedge sys_clk);
				chk({31'h0, pready}, 32'h0);
				@(posedge sys_clk);
				ce <= 1'b1;
			end
		join
		rd(apf_pkg::ARB_ADDR);
		chk(rd_val, 32'h10);
		chk({31'h0, default_grant_mask}, 32'h1);
	endtask

	task automatic t_strap();
		strap_pci <= 1'b1;
		strap_rmii <= 1'b1;
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rd(apf_pkg::PIN_ADDR);
		chk(rd_val, 32'h0800_0056);
		rd(apf_pkg::ARB_ADDR);
		chk(rd_val, 32'h0);
		chk({28'h0, port_d_pci, port_c_pci, port_f_rmii}, 32'hF);
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			final_report();
		end
	end

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		strap_pci = 1'b0;
		strap_rmii = 1'b0;
		cpu_irq_pending = 1'b0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_arb();
		t_pin();
		t_strobe();
		t_unmapped();
		t_stall();
		t_strap();
		final_report();
	end
endmodule
